// File: logic/sls_top.sv
/*
 * Lane 6 and 7 status registers, the first interrupt enable register,
 * threshold and control registers and a sticky interrupt status, all
 * behind an AXI4-Lite slave.
 * Assumes error counters and alignment logic run on aclk.
 */
// The AXI4-Lite slave port was decided locally.
`include "sls_defines.svh"

module sls_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sls_pkg::sls_addr_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire sls_pkg::sls_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output sls_pkg::sls_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire sls_pkg::sls_addr_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output sls_pkg::sls_word_t s_axi_rdata,
  output sls_pkg::sls_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sls_pkg::sls_byte_t lane6_disparity_count,
  input wire sls_pkg::sls_byte_t lane6_invalid_code_count,
  input wire sls_pkg::sls_byte_t lane6_stray_control_count,
  input wire logic lane6_deskew_in,
  input wire logic lane6_alignment_sync_in,
  input wire logic lane6_checksum_in,
  input wire logic lane6_frame_sync_in,
  input wire logic lane6_codegroup_sync_in,
  input wire sls_pkg::sls_byte_t lane7_disparity_count,
  input wire sls_pkg::sls_byte_t lane7_invalid_code_count,
  input wire sls_pkg::sls_byte_t lane7_stray_control_count,
  input wire logic lane7_deskew_in,
  input wire logic lane7_alignment_sync_in,
  input wire logic lane7_checksum_in,
  input wire logic lane7_frame_sync_in,
  input wire logic lane7_codegroup_sync_in,
  output logic skip_initial_alignment,
  output logic irq
);
  import sls_pkg::*;

  // -------------------------------------------------------------------
  // Lane status
  // -------------------------------------------------------------------
  // Lane 6 sits at index 0 and lane 7 at index 1 of every per-lane
  // array, so that the generate loop and the register map agree.
  // Counts and flags come from logic on aclk and need no synchroniser.
  sls_byte_t error_threshold;
  sls_byte_t lane_disp [2];
  sls_byte_t lane_inv [2];
  sls_byte_t lane_stray [2];
  logic [4:0] lane_flags [2];
  sls_byte_t lane_state [2];
  sls_byte_t lane_state_prev [2];
  sls_byte_t lane6_link_state;
  sls_byte_t lane7_link_state;

  assign lane_disp[0] = lane6_disparity_count;
  assign lane_disp[1] = lane7_disparity_count;
  assign lane_inv[0] = lane6_invalid_code_count;
  assign lane_inv[1] = lane7_invalid_code_count;
  assign lane_stray[0] = lane6_stray_control_count;
  assign lane_stray[1] = lane7_stray_control_count;
  assign lane_flags[0] = {lane6_deskew_in, lane6_alignment_sync_in,
    lane6_checksum_in, lane6_frame_sync_in, lane6_codegroup_sync_in};
  assign lane_flags[1] = {lane7_deskew_in, lane7_alignment_sync_in,
    lane7_checksum_in, lane7_frame_sync_in, lane7_codegroup_sync_in};

  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      sls_lane_status u_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .error_threshold(error_threshold),
        .disparity_count(lane_disp[lane]),
        .invalid_code_count(lane_inv[lane]),
        .stray_control_count(lane_stray[lane]),
        .deskew_ok(lane_flags[lane][4]),
        .alignment_sync_ok(lane_flags[lane][3]),
        .checksum_ok(lane_flags[lane][2]),
        .frame_sync_ok(lane_flags[lane][1]),
        .codegroup_sync_ok(lane_flags[lane][0]),
        .lane_state(lane_state[lane])
      );

      // The previous byte lets the interrupt logic see rising bits; it
      // resets with the status so that no false edge follows reset.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lane_state_prev[lane] <= `SLS_RESET_BYTE;
        end else begin
          lane_state_prev[lane] <= lane_state[lane];
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------
  // Register views
  // -------------------------------------------------------------------
  assign lane6_link_state = lane_state[0];
  assign lane7_link_state = lane_state[1];

  // -------------------------------------------------------------------
  // Write channel
  // -------------------------------------------------------------------
  // Address and data are latched separately so that either may come
  // first; the write is done once both are taken or held and no answer waits.
  // Each register is byte 0 of its word: a write without strobe 0
  // leaves it unchanged and is still answered.
  // Writes to read-only registers are ignored but answered OKAY; only
  // an address outside the map earns a decode error.
  logic aw_held;
  logic w_held;
  sls_addr_t aw_addr;
  sls_word_t w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held | aw_take;
  wire w_have = w_held | w_take;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;
  wire [`SLS_ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire [`SLS_IDX_W-1:0] wr_idx = wr_addr[`SLS_ADDR_W-1:2];
  wire wr_lane0 = do_write & wr_strb[0];
  wire sel_w_enable = (wr_idx == `SLS_IDX_IRQ_ENABLE);
  wire sel_w_threshold = (wr_idx == `SLS_IDX_THRESHOLD);
  wire sel_w_control = (wr_idx == `SLS_IDX_CONTROL);
  wire sel_w_clear = (wr_idx == `SLS_IDX_IRQ_CLEAR);
  wire sel_w_status = (wr_idx == `SLS_IDX_IRQ_STATUS);
  wire sel_w_lane = (wr_idx == `SLS_IDX_LANE6_STATE) |
    (wr_idx == `SLS_IDX_LANE7_STATE);
  wire wr_mapped = sel_w_enable | sel_w_threshold | sel_w_control |
    sel_w_clear | sel_w_status | sel_w_lane;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else begin
      aw_held <= aw_have & ~do_write;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= `SLS_ZERO_WORD;
      w_strb <= 4'h0;
    end else begin
      w_held <= w_have & ~do_write;
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // While the answer stands both readies stay low, which keeps a second
  // write from overtaking the first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? `SLS_RESP_OKAY : `SLS_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Software registers
  // -------------------------------------------------------------------
  sls_byte_t link_interrupt_enable_first;
  sls_byte_t irq_status;

  // Enable bits share the layout of the status byte, bit for bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_interrupt_enable_first <= `SLS_RESET_BYTE;
    end else if (wr_lane0 & sel_w_enable) begin
      link_interrupt_enable_first <= wr_data[7:0];
    end
  end

  // -------------------------------------------------------------------
  // Threshold and control
  // -------------------------------------------------------------------
  // The threshold resets to the top of the count range, so a fresh lane
  // flags an error only at a count of 255 until software picks a lower level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_threshold <= `SLS_RESET_THRESHOLD;
    end else if (wr_lane0 & sel_w_threshold) begin
      error_threshold <= wr_data[7:0];
    end
  end

  // Bit 0 of the control word is the only writable control bit.
  // The alignment logic acts on this bit; the deskew, sync, checksum
  // and frame flags are then meaningless to software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_initial_alignment <= 1'b0;
    end else if (wr_lane0 & sel_w_control) begin
      skip_initial_alignment <= wr_data[`SLS_BIT_SKIP_ALIGN];
    end
  end

  // -------------------------------------------------------------------
  // Interrupts
  // -------------------------------------------------------------------
  // A status bit is raised when the matching bit of either lane rises.
  // A rise in the same cycle as a clear keeps the bit set.
  wire [7:0] lane_rise = (lane_state[0] & ~lane_state_prev[0]) |
    (lane_state[1] & ~lane_state_prev[1]);
  wire [7:0] clear_mask = (wr_lane0 & sel_w_clear) ? wr_data[7:0] :
    `SLS_RESET_BYTE;
  wire [7:0] next_irq_status = (irq_status & ~clear_mask) | lane_rise;
  // The output follows the next status so that it rises with the status
  // bit itself; a newly written enable shows one cycle later.
  // Both lanes feed one status byte, so software reads the lane
  // registers to tell which lane raised an event.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `SLS_RESET_BYTE;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & link_interrupt_enable_first);
    end
  end

  // -------------------------------------------------------------------
  // Read channel
  // -------------------------------------------------------------------
  // The address is decoded while it is offered; the answer is registered
  // so that rdata and rresp stand unchanged until the master takes them.
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [`SLS_IDX_W-1:0] rd_idx = s_axi_araddr[`SLS_ADDR_W-1:2];
  wire sel_r_lane6 = (rd_idx == `SLS_IDX_LANE6_STATE);
  wire sel_r_lane7 = (rd_idx == `SLS_IDX_LANE7_STATE);
  wire sel_r_enable = (rd_idx == `SLS_IDX_IRQ_ENABLE);
  wire sel_r_threshold = (rd_idx == `SLS_IDX_THRESHOLD);
  wire sel_r_control = (rd_idx == `SLS_IDX_CONTROL);
  wire sel_r_status = (rd_idx == `SLS_IDX_IRQ_STATUS);
  wire sel_r_clear = (rd_idx == `SLS_IDX_IRQ_CLEAR);
  wire rd_mapped = sel_r_lane6 | sel_r_lane7 | sel_r_enable |
    sel_r_threshold | sel_r_control | sel_r_status | sel_r_clear;
  // The clear register is write-only and reads as zero.
  wire [7:0] rd_byte =
    sel_r_lane6 ? lane6_link_state :
    sel_r_lane7 ? lane7_link_state :
    sel_r_enable ? link_interrupt_enable_first :
    sel_r_threshold ? error_threshold :
    sel_r_control ? {7'h00, skip_initial_alignment} :
    sel_r_status ? irq_status :
    `SLS_RESET_BYTE;

  // One read at a time: a new address waits until the answer is taken.
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `SLS_ZERO_WORD;
      s_axi_rresp <= `SLS_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_mapped ? `SLS_RESP_OKAY : `SLS_RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // sls_top

// File: logic/sls_defines.svh
/*
 * Register indices, bit positions and reset values for the lane status
 * and interrupt enable bank.
 * Assumes a byte address of four times the register index on the bus.
 */
`ifndef SLS_DEFINES_SVH
`define SLS_DEFINES_SVH

// ---------------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------------
`define SLS_ADDR_W 14
`define SLS_IDX_W 12

// ---------------------------------------------------------------------
// Register indices (byte address is index times four)
// ---------------------------------------------------------------------
`define SLS_IDX_LANE6_STATE 12'h4B6
`define SLS_IDX_LANE7_STATE 12'h4B7
`define SLS_IDX_IRQ_ENABLE 12'h4B8
`define SLS_IDX_THRESHOLD 12'h4C0
`define SLS_IDX_CONTROL 12'h4C1
`define SLS_IDX_IRQ_STATUS 12'h4C2
`define SLS_IDX_IRQ_CLEAR 12'h4C3

// ---------------------------------------------------------------------
// Lane status bit positions, shared by enable, status and clear, and the control bit
// ---------------------------------------------------------------------
`define SLS_BIT_DISPARITY 7
`define SLS_BIT_INVALID_CODE 6
`define SLS_BIT_STRAY_CONTROL 5
`define SLS_BIT_DESKEW 4
`define SLS_BIT_ALIGN_SYNC 3
`define SLS_BIT_CHECKSUM 2
`define SLS_BIT_FRAME_SYNC 1
`define SLS_BIT_CODEGROUP_SYNC 0
`define SLS_BIT_SKIP_ALIGN 0

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define SLS_RESET_BYTE 8'h00
`define SLS_RESET_THRESHOLD 8'hFF
`define SLS_ZERO_WORD 32'h0000_0000

// ---------------------------------------------------------------------
// Bus responses
// ---------------------------------------------------------------------
`define SLS_RESP_OKAY 2'h0
`define SLS_RESP_DECERR 2'h3

`endif

// File: logic/sls_pkg.sv
/*
 * Types shared by the lane status bank.
 * Assumes sls_defines.svh supplies the numeric constants.
 */
package sls_pkg;
  typedef logic [7:0] sls_byte_t;
  typedef logic [31:0] sls_word_t;
  typedef logic [1:0] sls_resp_t;
  typedef logic [13:0] sls_addr_t;
endpackage

// File: logic/sls_lane_status.sv
/*
 * One lane's status byte: three error counts compared against the
 * threshold and five synchronisation flags, registered.
 * Assumes counts and flags come from logic on the same clock.
 */
`include "sls_defines.svh"

module sls_lane_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sls_pkg::sls_byte_t error_threshold,
  input wire sls_pkg::sls_byte_t disparity_count,
  input wire sls_pkg::sls_byte_t invalid_code_count,
  input wire sls_pkg::sls_byte_t stray_control_count,
  input wire logic deskew_ok,
  input wire logic alignment_sync_ok,
  input wire logic checksum_ok,
  input wire logic frame_sync_ok,
  input wire logic codegroup_sync_ok,
  output sls_pkg::sls_byte_t lane_state
);
  import sls_pkg::*;

  wire sls_byte_t next_lane_state;

  assign next_lane_state[`SLS_BIT_DISPARITY] =
    (disparity_count >= error_threshold);
  assign next_lane_state[`SLS_BIT_INVALID_CODE] =
    (invalid_code_count >= error_threshold);
  assign next_lane_state[`SLS_BIT_STRAY_CONTROL] =
    (stray_control_count >= error_threshold);
  assign next_lane_state[`SLS_BIT_DESKEW] = deskew_ok;
  assign next_lane_state[`SLS_BIT_ALIGN_SYNC] = alignment_sync_ok;
  assign next_lane_state[`SLS_BIT_CHECKSUM] = checksum_ok;
  assign next_lane_state[`SLS_BIT_FRAME_SYNC] = frame_sync_ok;
  assign next_lane_state[`SLS_BIT_CODEGROUP_SYNC] =
    codegroup_sync_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_state <= `SLS_RESET_BYTE;
    end else begin
      lane_state <= next_lane_state;
    end
  end
endmodule // sls_lane_status

// File: bench/sls_far_tx.sv
/*
 * Behavioural model of the link transmitter and lane monitors that feed
 * the status inputs: error counts and five sync levels per lane.
 * Assumes the bench sets the wanted state and the lag in cycles.
 */
// ---------------------------------------------------------------------
// Far side of the lanes
// ---------------------------------------------------------------------
module sls_far_tx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] lag,
  input wire logic [47:0] want_cnt,
  input wire logic [9:0] want_flg,
  output logic [47:0] cnt,
  output logic [9:0] flg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;

  // A slow link settles only after lag cycles, so the bench must not
  // read the status in the meantime and expect the new state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 48'h0;
      flg <= 10'h0;
      wait_q <= 4'h0;
    end else if ({want_cnt, want_flg} == {cnt, flg}) begin
      wait_q <= lag;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else begin
      cnt <= want_cnt;
      flg <= want_flg;
    end
  end
endmodule // sls_far_tx

// File: bench/sls_checker.sv
/*
 * Concurrent checks on the ports of the lane status bank.
 * Assumes it is bound to sls_top and sees that module's ports only.
 */
`include "sls_defines.svh"
// ---------------------------------------------------------------------
// Checker
// ---------------------------------------------------------------------
module sls_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sls_pkg::sls_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire sls_pkg::sls_word_t s_axi_rdata,
  input wire sls_pkg::sls_resp_t s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sls_pkg::sls_resp_t s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic lane6_codegroup_sync_in,
  input wire logic lane7_deskew_in,
  input wire logic lane7_alignment_sync_in,
  input wire logic lane7_checksum_in,
  input wire logic lane7_frame_sync_in,
  input wire logic lane7_codegroup_sync_in,
  input wire logic irq
);
  import sls_pkg::*;
  logic [11:0] rd_idx;
  logic mapped;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_idx <= 12'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_idx <= s_axi_araddr[13:2];
    end
  end
  assign mapped = rd_idx inside {`SLS_IDX_LANE6_STATE, `SLS_IDX_LANE7_STATE,
    `SLS_IDX_IRQ_ENABLE, `SLS_IDX_THRESHOLD, `SLS_IDX_CONTROL,
    `SLS_IDX_IRQ_STATUS, `SLS_IDX_IRQ_CLEAR};

  sequence s_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_l7_read;
    $rose(s_axi_rvalid) && rd_idx == `SLS_IDX_LANE7_STATE;
  endsequence
  sequence s_l6_read;
    $rose(s_axi_rvalid) && rd_idx == `SLS_IDX_LANE6_STATE;
  endsequence

  AST_RD_TURN: assert property (s_take |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_RESET_IDLE: assert property ($rose(aresetn) |->
    !s_axi_rvalid && !s_axi_bvalid && !irq)
    else $error("outputs busy after reset");
  AST_L7_FLAGS: assert property (
    s_l7_read ##0 $past(aresetn, 2) |->
    s_axi_rdata[4:0] == {$past(lane7_deskew_in, 2),
    $past(lane7_alignment_sync_in, 2), $past(lane7_checksum_in, 2),
    $past(lane7_frame_sync_in, 2), $past(lane7_codegroup_sync_in, 2)})
    else $error("lane 7 sync bits wrong");
  AST_L6_SYNC: assert property (
    s_l6_read ##0 $past(aresetn, 2) |->
    s_axi_rdata[0] == $past(lane6_codegroup_sync_in, 2))
    else $error("lane 6 code group bit wrong");
  AST_HIGH_ZERO: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_DECODE: assert property ($rose(s_axi_rvalid) |-> s_axi_rresp ==
    (mapped ? `SLS_RESP_OKAY : `SLS_RESP_DECERR))
    else $error("read response wrong");
endmodule // sls_checker

bind sls_top sls_checker sls_checker_i (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .lane6_codegroup_sync_in, .lane7_deskew_in,
  .lane7_alignment_sync_in, .lane7_checksum_in, .lane7_frame_sync_in,
  .lane7_codegroup_sync_in, .irq);

// File: bench/tb.sv
/*
 * Self-checking bench for the lane status bank over AXI4-Lite.
 * Assumes sls_far_tx feeds the lane inputs and the checker is bound.
 */
`include "sls_defines.svh"
// ---------------------------------------------------------------------
// Bench top
// ---------------------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sls_pkg::*;
  localparam sls_addr_t A_L6 = {`SLS_IDX_LANE6_STATE, 2'h0};
  localparam sls_addr_t A_L7 = {`SLS_IDX_LANE7_STATE, 2'h0};
  localparam sls_addr_t A_EN = {`SLS_IDX_IRQ_ENABLE, 2'h0};
  localparam sls_addr_t A_THR = {`SLS_IDX_THRESHOLD, 2'h0};
  localparam sls_addr_t A_CTL = {`SLS_IDX_CONTROL, 2'h0};
  localparam sls_addr_t A_IST = {`SLS_IDX_IRQ_STATUS, 2'h0};
  localparam sls_addr_t A_ICL = {`SLS_IDX_IRQ_CLEAR, 2'h0};
  localparam sls_addr_t A_BAD = 14'h1400;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic skip_initial_alignment, irq;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb, lag;
  sls_addr_t s_axi_awaddr, s_axi_araddr;
  sls_word_t s_axi_wdata, s_axi_rdata, rd, msk;
  sls_resp_t s_axi_bresp, s_axi_rresp, rs;
  logic [47:0] want_cnt, cnt;
  logic [9:0] want_flg, flg;
  int errors, checks_done, slow, k, v;

  sls_far_tx sls_far_tx_i (.*);
  sls_top sls_top_i (.*,
    .lane6_disparity_count(cnt[47:40]), .lane6_invalid_code_count(cnt[39:32]),
    .lane6_stray_control_count(cnt[31:24]), .lane6_deskew_in(flg[9]),
    .lane6_alignment_sync_in(flg[8]), .lane6_checksum_in(flg[7]),
    .lane6_frame_sync_in(flg[6]), .lane6_codegroup_sync_in(flg[5]),
    .lane7_disparity_count(cnt[23:16]), .lane7_invalid_code_count(cnt[15:8]),
    .lane7_stray_control_count(cnt[7:0]), .lane7_deskew_in(flg[4]),
    .lane7_alignment_sync_in(flg[3]), .lane7_checksum_in(flg[2]),
    .lane7_frame_sync_in(flg[1]), .lane7_codegroup_sync_in(flg[0]));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_w(input string what, input sls_word_t e,
    input sls_word_t g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_r(input string what, input sls_resp_t e,
    input sls_resp_t g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic lost(input string what);
    errors++;
    $display("Error %s expected answer seen none", what);
    tally_and_finish();
  endtask

  // Signals change only after a rising edge, so what is seen at the
  // falling edge is exactly what the next rising edge samples.
  task automatic wr(input sls_addr_t a, input sls_word_t d,
    input sls_resp_t e);
    int n;
    bit b, ta, tw;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (slow == 0);
    for (n = 0; n < 40 && !b; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= !b && (n + 1 >= slow);
    end
    if (!b) lost("write");
    chk_r("write resp", e, rs);
    @(posedge aclk);
  endtask

  task automatic rd_chk(input string what, input sls_addr_t a,
    input sls_word_t e);
    int n;
    bit r, ta;
    r = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (slow == 0);
    for (n = 0; n < 40 && !r; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !r && (n + 1 >= slow);
    end
    if (!r) lost("read");
    chk_w(what, e, rd & msk);
    chk_r("read resp", a == A_BAD ? `SLS_RESP_DECERR : `SLS_RESP_OKAY, rs);
    @(posedge aclk);
  endtask

  task automatic lanes(input logic [47:0] c, input logic [9:0] f);
    want_cnt <= c;
    want_flg <= f;
    repeat (lag + 4) @(posedge aclk);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge aclk);
    chk_w("irq", {31'h0, e}, {31'h0, irq});
    @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    {s_axi_arvalid, s_axi_rready, aresetn} <= 3'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} <= 10'h00F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 60'h0;
    {want_cnt, want_flg, lag} <= 62'h0;
    msk = 32'hFFFF_FFFF;
    slow = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("lane6", A_L6, 32'h0);
    rd_chk("lane7", A_L7, 32'h0);
    rd_chk("enable", A_EN, 32'h0);
    rd_chk("threshold", A_THR, 32'hFF);
    wr(A_EN, 32'hFF, `SLS_RESP_OKAY);
    rd_chk("enable", A_EN, 32'hFF);
    slow = 3;
    wr(A_EN, 32'h5A, `SLS_RESP_OKAY);
    rd_chk("enable", A_EN, 32'h5A);
    wr(A_L7, 32'hFF, `SLS_RESP_OKAY);
    rd_chk("lane7", A_L7, 32'h0);
    wr(A_BAD, 32'h0, `SLS_RESP_DECERR);
    rd_chk("unmapped", A_BAD, 32'h0);
    slow = 0;
    wr(A_THR, 32'h10, `SLS_RESP_OKAY);
    // One below, at and one above the threshold for each error kind.
    for (k = 0; k < 3; k++) begin
      for (v = 0; v < 3; v++) begin
        lanes(48'(15 + v) << (16 - 8 * k), 10'h0);
        rd_chk("count", A_L7, v == 0 ? 32'h0 : 32'h80 >> k);
      end
    end
    lag <= 4'h3;
    for (k = 0; k < 5; k++) begin
      lanes(48'h0, 10'((1 << k) | (1 << (9 - k))));
      rd_chk("lane7 flag", A_L7, 32'(1 << k));
      rd_chk("lane6 flag", A_L6, 32'(1 << (4 - k)));
    end
    wr(A_CTL, 32'h1, `SLS_RESP_OKAY);
    @(negedge aclk);
    chk_w("skip", 32'h1, {31'h0, skip_initial_alignment});
    @(posedge aclk);
    lanes(48'hFF, 10'h3FF);
    msk = 32'hFFFF_FFE1;
    rd_chk("lane7 masked", A_L7, 32'h21);
    msk = 32'hFFFF_FFFF;
    wr(A_CTL, 32'h0, `SLS_RESP_OKAY);
    wr(A_EN, 32'h0, `SLS_RESP_OKAY);
    lanes(48'h0, 10'h0);
    wr(A_ICL, 32'hFF, `SLS_RESP_OKAY);
    rd_chk("irq status", A_IST, 32'h0);
    lanes(48'h0, 10'h004);
    rd_chk("irq status", A_IST, 32'h04);
    irq_chk(1'b0);
    wr(A_EN, 32'h04, `SLS_RESP_OKAY);
    irq_chk(1'b1);
    wr(A_ICL, 32'h04, `SLS_RESP_OKAY);
    irq_chk(1'b0);
    rd_chk("irq status", A_IST, 32'h0);
    rd_chk("irq clear", A_ICL, 32'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("enable", A_EN, 32'h0);
    tally_and_finish();
  end
endmodule // tb
